// [core/ups_map.svh]
/*
 Constants of the parallel transceiver port: clock rates, mode codes, reset values.
 Assumes inclusion by ups_pkg only, compiled ahead of ups_port.
*/
`ifndef UPS_MAP_SVH
`define UPS_MAP_SVH

`define UPS_SYS_HZ 200000000
`define UPS_REF_HZ 48000000
`define UPS_BUS_HZ 30000000
`define UPS_LINK_HZ 60000000
`define UPS_LINK_PER_BUS (`UPS_LINK_HZ / `UPS_BUS_HZ)

`define UPS_DATA_W 16
`define UPS_BYTE_W 8

`define UPS_MODE_UTMI 4'h0
`define UPS_MODE_DEVTEST 4'h1
`define UPS_MODE_NORMAL 4'h2
`define UPS_MODE_SQTEST 4'h3

`define UPS_LS_RST 2'h0
`define UPS_WORD_RST 16'h0000
`define UPS_BYTE_RST 8'h00

`endif

// [core/ups_pkg.sv]
/*
 Types of the parallel transceiver port: operating modes and state records.
 Assumes ups_map.svh is on the include path.
*/
`include "ups_map.svh"

package ups_pkg;
	typedef enum logic [1:0] {
		UPS_OP_UTMI = 2'b00,
		UPS_OP_DEVTEST = 2'b01,
		UPS_OP_NORMAL = 2'b10,
		UPS_OP_SQTEST = 2'b11
	} ups_op_t;

	typedef struct packed {
		logic hrst_n;
		logic susp_n;
		logic speed;
		logic term;
		logic [3:0] mode;
		logic crc;
		logic txq;
		logic ackt;
		logic txt;
		logic [1:0] ls;
	} ups_spin_t;

	typedef struct packed {
		logic reqt;
		logic hold;
		logic txq;
		logic ackt;
		logic [15:0] dat;
		logic wid;
		logic [1:0] ls;
	} ups_lpin_t;

	typedef struct packed {
		ups_spin_t s1;
		ups_spin_t s2;
		logic hs;
		ups_op_t op;
		logic pu;
		logic stby;
		logic crc_en;
		logic txa;
		logic abort;
		logic crc_d;
		logic [7:0] lo;
		logic have_lo;
		logic err_st;
		logic [15:0] word;
		logic m_val;
		logic m_wide;
		logic m_last;
		logic m_crc;
		logic m_err;
		logic req_t;
		logic rdy;
		logic ack_t;
		logic [15:0] tx_word;
		logic tx_odd;
		logic tx_stb;
		logic [1:0] ls;
	} ups_sys_t;

	typedef struct packed {
		ups_lpin_t l1;
		ups_lpin_t l2;
		logic bco;
		logic req_seen;
		logic ract;
		logic rval;
		logic [15:0] dat;
		logic doe;
		logic wv;
		logic crce;
		logic rxe;
		logic end_pend;
		logic trdy;
		logic cap_due;
		logic tx_t;
		logic [15:0] cap;
		logic cap_odd;
		logic [1:0] ls;
	} ups_link_t;
endpackage

// [core/ups_port.sv]
/*
 Parallel 16-bit engine-side port of a USB 2.0 transceiver: receive words,
 transmit handshake with bus turnaround, odd-byte packing, error flags, modes.
 Assumes link_clk is twice the bus clock, made from the 48 MHz reference by a
 PLL outside this block, and that the shared logic runs on clk_sys.
*/
`timescale 1ns/100ps
`default_nettype none

module ups_port
	import ups_pkg::*;
(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic link_clk,
	input wire logic hard_reset_n,
	input wire logic suspend_n,
	input wire logic speed_select,
	input wire logic termination_select,
	input wire logic [3:0] mode,
	input wire logic crc_enable_abort,
	input wire logic transmit_request,
	input wire logic [15:0] parallel_data_bus_in,
	input wire logic word_width_valid_in,
	input wire logic [1:0] line_state_raw,
	input wire logic [7:0] rx_byte,
	input wire logic rx_byte_valid,
	input wire logic rx_end,
	input wire logic rx_crc_bad,
	input wire logic rx_err,
	output logic rx_byte_ready,
	output logic hs_mode,
	output ups_op_t op_mode,
	output logic pullup_source_out,
	output logic pullup_source_oe,
	output logic standby,
	output logic crc_check_en,
	output logic tx_active,
	output logic tx_abort,
	output logic [15:0] tx_word,
	output logic tx_odd,
	output logic tx_word_strobe,
	output logic bus_clock_out,
	output logic receive_active,
	output logic receive_valid,
	output logic crc_error_flag,
	output logic receive_error_flag,
	output logic transmit_ready,
	output logic [15:0] parallel_data_bus_out,
	output logic parallel_data_bus_oe,
	output logic word_width_valid_out,
	output logic word_width_valid_oe,
	output logic [1:0] line_state_out
);
	ups_sys_t q, n;
	ups_link_t lq, ln;
	logic tx_busy;

	generate
		if (`UPS_LINK_PER_BUS != 2) begin : g_bad_ratio
			$error("link clock must be twice the bus clock");
		end
	endgenerate

	// System domain: modes, byte packing, word handshake toward the link
	always_comb begin
		n = q;
		// The link's receive acknowledge toggle crosses through the same two flops
		n.s1 = {hard_reset_n, suspend_n, speed_select, termination_select, mode,
			crc_enable_abort, transmit_request, lq.req_seen, lq.tx_t, line_state_raw};
		n.s2 = q.s1;
		n.stby = !q.s2.hrst_n || !q.s2.susp_n;
		n.hs = !q.s2.speed;
		case (q.s2.mode)
			`UPS_MODE_UTMI: n.op = UPS_OP_UTMI;
			`UPS_MODE_DEVTEST: n.op = UPS_OP_DEVTEST;
			`UPS_MODE_SQTEST: n.op = UPS_OP_SQTEST;
			default: n.op = UPS_OP_NORMAL;
		endcase
		// High-speed chirp and SE0 termination keep the pull-up off
		n.pu = q.s2.speed && q.s2.term && !n.stby;
		n.txa = q.s2.txq;
		n.crc_en = q.s2.crc && !q.s2.txq;
		// Only the rising edge aborts, so a held enable gives a single pulse
		n.crc_d = q.s2.crc;
		n.abort = q.s2.txq && q.s2.crc && !q.crc_d && q.txa;
		n.ls = q.s2.ls;
		n.tx_stb = 1'b0;
		if (q.s2.txt != q.ack_t) begin
			n.tx_word = lq.cap;
			n.tx_odd = lq.cap_odd;
			n.tx_stb = 1'b1;
			n.ack_t = q.s2.txt;
		end
		if (rx_err) begin
			n.err_st = 1'b1;
		end
		if (n.stby) begin
			n.have_lo = 1'b0;
			n.err_st = 1'b0;
			n.abort = 1'b0;
		end else if (q.rdy && rx_end) begin
			n.word = {`UPS_BYTE_RST, q.lo};
			n.m_val = q.have_lo;
			n.m_wide = 1'b0;
			n.m_last = 1'b1;
			n.m_crc = rx_crc_bad && q.crc_en;
			n.m_err = q.err_st || rx_err;
			n.err_st = 1'b0;
			n.have_lo = 1'b0;
			n.req_t = !q.req_t;
		end else if (q.rdy && rx_byte_valid) begin
			if (!q.have_lo) begin
				n.lo = rx_byte;
				n.have_lo = 1'b1;
			end else begin
				n.word = {rx_byte, q.lo};
				n.m_val = 1'b1;
				n.m_wide = 1'b1;
				n.m_last = 1'b0;
				n.m_crc = 1'b0;
				n.m_err = 1'b0;
				n.have_lo = 1'b0;
				n.req_t = !q.req_t;
			end
		end
		// Only one word may be in flight; the message fields hold until acknowledged
		n.rdy = !n.stby && (n.req_t == q.s2.ackt) && (q.req_t == q.s2.ackt);
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			q <= '0;
			q.op <= UPS_OP_UTMI;
			q.stby <= 1'b1;
		end else begin
			q <= n;
		end
	end

	// Link domain: bus clock, word launch on its fall, capture on its rise
	always_comb begin
		ln = lq;
		ln.l1 = {q.req_t, q.stby, transmit_request, q.ack_t, parallel_data_bus_in,
			word_width_valid_in, line_state_raw};
		ln.l2 = lq.l1;
		tx_busy = lq.l2.ackt != lq.tx_t;
		if (lq.l2.hold) begin
			ln.bco = 1'b0;
			ln.ract = 1'b0;
			ln.rval = 1'b0;
			ln.crce = 1'b0;
			ln.rxe = 1'b0;
			ln.trdy = 1'b0;
			ln.doe = 1'b0;
			ln.end_pend = 1'b0;
			ln.cap_due = 1'b0;
			ln.req_seen = lq.l2.reqt;
		end else begin
			ln.bco = !lq.bco;
			ln.ls = lq.l2.ls;
			if (!lq.bco) begin
				// Pins reach l2 two link edges late: this rise sees the ready cycle's word
				if (lq.cap_due) begin
					ln.cap = lq.l2.dat;
					ln.cap_odd = !lq.l2.wid;
					ln.tx_t = !lq.tx_t;
				end
			end else begin
				ln.rval = 1'b0;
				ln.crce = 1'b0;
				ln.rxe = 1'b0;
				ln.doe = !lq.l2.txq;
				ln.cap_due = lq.trdy;
				ln.trdy = lq.l2.txq && !lq.ract && !tx_busy && !lq.trdy;
				if (lq.end_pend) begin
					ln.ract = 1'b0;
					ln.end_pend = 1'b0;
				end else if (lq.l2.reqt != lq.req_seen) begin
					ln.req_seen = lq.l2.reqt;
					ln.ract = 1'b1;
					ln.rval = q.m_val;
					ln.dat = q.word;
					ln.wv = q.m_wide;
					ln.crce = q.m_last && q.m_crc;
					ln.rxe = q.m_last && q.m_err;
					ln.end_pend = q.m_last;
				end
			end
		end
	end

	always_ff @(posedge link_clk or negedge resetn) begin
		if (!resetn) begin
			lq <= '0;
			lq.doe <= 1'b1;
		end else begin
			lq <= ln;
		end
	end

	assign rx_byte_ready = q.rdy;
	assign hs_mode = q.hs;
	assign op_mode = q.op;
	assign pullup_source_out = q.pu;
	assign pullup_source_oe = q.pu;
	assign standby = q.stby;
	assign crc_check_en = q.crc_en;
	assign tx_active = q.txa;
	assign tx_abort = q.abort;
	assign tx_word = q.tx_word;
	assign tx_odd = q.tx_odd;
	assign tx_word_strobe = q.tx_stb;
	assign bus_clock_out = lq.bco;
	assign receive_active = lq.ract;
	assign receive_valid = lq.rval;
	assign crc_error_flag = lq.crce;
	assign receive_error_flag = lq.rxe;
	assign transmit_ready = lq.trdy;
	assign parallel_data_bus_out = lq.dat;
	assign parallel_data_bus_oe = lq.doe;
	assign word_width_valid_out = lq.wv;
	assign word_width_valid_oe = lq.doe;
	// The bus clock stops in standby, so the line state falls back to the system copy
	assign line_state_out = q.stby ? q.ls : lq.ls;

	sequence seq_fall_edge;
		lq.bco && !lq.l2.hold;
	endsequence

	sequence seq_word_launch;
		seq_fall_edge ##0 (lq.l2.reqt != lq.req_seen) && !lq.end_pend;
	endsequence

	chk_bus_turn: assert property (@(posedge link_clk) disable iff (!resetn)
		seq_fall_edge ##0 lq.l2.txq |=> !parallel_data_bus_oe && !word_width_valid_oe)
		else $error("data bus driven under transmit request");

	chk_valid_in_active: assert property (@(posedge link_clk) disable iff (!resetn)
		receive_valid |-> receive_active)
		else $error("receive valid outside receive active");

	chk_launch_word: assert property (@(posedge link_clk) disable iff (!resetn)
		seq_word_launch |=> receive_active && parallel_data_bus_out == $past(q.word))
		else $error("word not launched with receive active");

	chk_ready_gate: assert property (@(posedge link_clk) disable iff (!resetn)
		$rose(transmit_ready) |-> $past(lq.l2.txq) && !receive_active)
		else $error("transmit ready without transmit request");

	chk_capture_word: assert property (@(posedge link_clk) disable iff (!resetn)
		!lq.bco && !lq.l2.hold && lq.cap_due |=>
		$changed(lq.tx_t) && lq.cap == $past(lq.l2.dat))
		else $error("ready word not captured");

	chk_active_drop: assert property (@(posedge link_clk) disable iff (!resetn)
		seq_fall_edge ##0 lq.end_pend |=> !receive_active ##1 !receive_active)
		else $error("receive active held past last word");

	chk_bus_clock: assert property (@(posedge link_clk) disable iff (!resetn)
		(!lq.l2.hold)[*3] |-> bus_clock_out == $past(bus_clock_out, 2)
		&& bus_clock_out != $past(bus_clock_out))
		else $error("bus clock not running at half link rate");

	chk_standby_quiet: assert property (@(posedge link_clk) disable iff (!resetn)
		lq.l2.hold |=> !receive_active && !transmit_ready && !bus_clock_out)
		else $error("link active in standby");

	chk_crc_gate: assert property (@(posedge clk_sys) disable iff (!resetn)
		!q.stby && q.rdy && rx_end && !crc_check_en |=> !q.m_crc && q.m_last)
		else $error("crc error passed while checking disabled");

	chk_odd_width: assert property (@(posedge clk_sys) disable iff (!resetn)
		!q.stby && q.rdy && rx_end && q.have_lo |=> q.m_val && !q.m_wide
		&& q.word[7:0] == $past(q.lo))
		else $error("odd final byte not marked narrow");

	chk_pullup_hs: assert property (@(posedge clk_sys) disable iff (!resetn)
		hs_mode |-> !pullup_source_oe)
		else $error("pull-up driven at high speed");

	chk_abort_pulse: assert property (@(posedge clk_sys) disable iff (!resetn)
		q.txa && q.s2.txq && q.s2.crc && !q.crc_d && !q.stby |=> tx_abort
		##1 !tx_abort)
		else $error("abort not signalled once");
endmodule

`default_nettype wire

// [verif/ups_sie_model.sv]
/*
 Model of the external engine on the transceiver's parallel port.
 Assumes the bench resolves the shared pins from both output enables.
*/
`timescale 1ns/100ps
`default_nettype none
module ups_sie_model (
	input wire logic bco,
	input wire logic ract,
	input wire logic rval,
	input wire logic [15:0] dout,
	input wire logic wv,
	input wire logic crce,
	input wire logic rxe,
	input wire logic trdy,
	input wire logic doe,
	output logic treq,
	output logic [15:0] tdat,
	output logic twv
);
	logic [16:0] q[$];
	logic crc_seen = 0;
	logic err_seen = 0;
	int bad = 0;
	initial begin
		treq = 0;
		tdat = 16'h0000;
		twv = 1;
	end
	// Everything on the port changes at bus falls, so the rise is mid-cycle
	always @(posedge bco) begin
		if (rval === 1'b1) q.push_back({wv, dout});
		if (rval === 1'b1 && ract !== 1'b1) bad++;
		if (trdy === 1'b1 && (ract === 1'b1 || doe !== 1'b0 || !treq)) bad++;
		if (crce === 1'b1) crc_seen = 1;
		if (rxe === 1'b1) err_seen = 1;
	end
	// Word held until the rise that sees ready, or for at most 100 bus clock rises
	task automatic send(input logic [15:0] w, input logic odd, input logic last);
		int n;
		n = 0;
		if (!treq) begin
			@(posedge bco);
			#1;
		end
		treq = 1;
		tdat = w;
		twv = !odd;
		do begin
			@(posedge bco);
			n++;
		end while (trdy !== 1'b1 && n < 100);
		#1;
		if (last) begin
			treq = 0;
			tdat = ~w;
			twv = odd;
		end
	endtask
endmodule
`default_nettype wire

// [verif/usb_phy_sie_parallel_port_tb.sv]
/*
 Self-checking bench of the parallel transceiver port.
 Assumes the design package and the engine model are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module usb_phy_sie_parallel_port_tb;
	import ups_pkg::*;
	logic clk_sys = 0, resetn = 0, link_clk = 0, hard_reset_n = 0, suspend_n = 0;
	logic speed_select = 1, termination_select = 1, crc_enable_abort = 0;
	logic rx_byte_valid = 0, rx_end = 0, rx_crc_bad = 0, rx_err = 0;
	logic [3:0] mode = 4'h0;
	logic [1:0] line_state_raw = 2'h0;
	logic [7:0] rx_byte = 8'h00;
	logic rx_byte_ready, hs_mode, pullup_source_out, pullup_source_oe, standby, crc_check_en;
	logic tx_active, tx_abort, tx_odd, tx_word_strobe, bus_clock_out, receive_active;
	logic receive_valid, crc_error_flag, receive_error_flag, transmit_ready;
	logic parallel_data_bus_oe, word_width_valid_out, word_width_valid_oe, transmit_request, m_wv;
	logic [15:0] tx_word, parallel_data_bus_out, m_dat;
	logic [1:0] line_state_out;
	ups_op_t op_mode;
	logic [16:0] txq[$];
	int errors = 0, checks_done = 0, cycles = 0, aborts = 0, n;
	wire logic [15:0] pins = parallel_data_bus_oe ? parallel_data_bus_out : m_dat;
	wire logic wv_pin = word_width_valid_oe ? word_width_valid_out : m_wv;

	ups_port dut (.clk_sys, .resetn, .link_clk, .hard_reset_n, .suspend_n, .speed_select,
		.termination_select, .mode, .crc_enable_abort, .transmit_request,
		.parallel_data_bus_in(pins), .word_width_valid_in(wv_pin), .line_state_raw, .rx_byte,
		.rx_byte_valid, .rx_end, .rx_crc_bad, .rx_err, .rx_byte_ready, .hs_mode, .op_mode,
		.pullup_source_out, .pullup_source_oe, .standby, .crc_check_en, .tx_active, .tx_abort,
		.tx_word, .tx_odd, .tx_word_strobe, .bus_clock_out, .receive_active, .receive_valid,
		.crc_error_flag, .receive_error_flag, .transmit_ready, .parallel_data_bus_out,
		.parallel_data_bus_oe, .word_width_valid_out, .word_width_valid_oe, .line_state_out);

	ups_sie_model m (.bco(bus_clock_out), .ract(receive_active), .rval(receive_valid),
		.dout(parallel_data_bus_out), .wv(word_width_valid_out), .crce(crc_error_flag),
		.rxe(receive_error_flag), .trdy(transmit_ready), .doe(parallel_data_bus_oe),
		.treq(transmit_request), .tdat(m_dat), .twv(m_wv));

	always #2.5 clk_sys = ~clk_sys;
	// Odd start offset keeps the link edges off the system edges
	initial begin
		#1.3;
		forever #7.5 link_clk = ~link_clk;
	end

	always @(posedge clk_sys) begin
		if (tx_word_strobe === 1'b1) txq.push_back({tx_odd, tx_word});
		if (tx_abort === 1'b1) aborts++;
		cycles++;
		if (cycles == 40000) begin
			errors++;
			end_sim();
		end
	end

	task automatic end_sim();
		if (errors == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge clk_sys);
		#1;
	endtask

	// Request held until the edge that samples ready high
	task automatic put(input logic e, input logic [7:0] b);
		int k;
		k = 0;
		rx_byte = b;
		rx_end = e;
		rx_byte_valid = !e;
		do begin
			@(posedge clk_sys);
			k++;
		end while (rx_byte_ready !== 1'b1 && k < 2000);
		#1;
	endtask

	task automatic pkt(input logic [7:0] b[$], input logic c, input logic x);
		rx_crc_bad = c;
		rx_err = x;
		foreach (b[i]) put(0, b[i]);
		put(1, 8'h00);
		rx_end = 0;
		rx_err = 0;
	endtask

	task automatic rx_wait(input int k);
		int t;
		t = 0;
		while ((m.q.size() < k || receive_active !== 1'b0) && t < 1000) begin
			cyc(1);
			t++;
		end
		cyc(20);
	endtask

	initial begin
		cyc(20);
		resetn = 1;
		chk("standby", standby, 1);
		line_state_raw = 2'h1;
		cyc(10);
		chk("ls_susp", line_state_out, 2'h1);
		hard_reset_n = 1;
		suspend_n = 1;
		for (int i = 0; i < 5; i++) begin
			mode = i[3:0];
			cyc(6);
			chk("op_mode", op_mode, i == 0 ? UPS_OP_UTMI : i == 1 ? UPS_OP_DEVTEST :
				i == 3 ? UPS_OP_SQTEST : UPS_OP_NORMAL);
		end
		mode = 4'h0;
		chk("standby", standby, 0);
		speed_select = 0;
		cyc(6);
		chk("hs", hs_mode, 1);
		chk("pu_oe", pullup_source_oe, 0);
		speed_select = 1;
		cyc(6);
		chk("hs", hs_mode, 0);
		chk("pu_oe", pullup_source_oe, 1);
		line_state_raw = 2'h2;
		cyc(30);
		chk("ls", line_state_out, 2'h2);
		crc_enable_abort = 1;
		cyc(6);
		chk("crc_en", crc_check_en, 1);
		pkt('{8'hA1, 8'hB2, 8'hC3}, 1, 0);
		rx_wait(2);
		chk("w0", m.q[0], {1'b1, 16'hB2A1});
		chk("w1", m.q[1][7:0], 8'hC3);
		chk("w1_wv", m.q[1][16], 0);
		chk("crc", m.crc_seen, 1);
		chk("rxe", m.err_seen, 0);
		m.q.delete();
		m.crc_seen = 0;
		crc_enable_abort = 0;
		cyc(6);
		pkt('{8'h5D, 8'hE4}, 1, 1);
		rx_wait(1);
		chk("w2", m.q[0], {1'b1, 16'hE45D});
		chk("nwords", m.q.size(), 1);
		chk("crc_off", m.crc_seen, 0);
		chk("rxe", m.err_seen, 1);
		m.send(16'hA55A, 0, 0);
		m.send(16'h00C3, 1, 1);
		for (n = 0; txq.size() < 2 && n < 200; n++) cyc(1);
		chk("tx0", txq[0], {1'b0, 16'hA55A});
		chk("tx1", txq[1], {1'b1, 16'h00C3});
		fork
			m.send(16'h1234, 0, 1);
			begin
				for (n = 0; tx_active !== 1'b1 && n < 200; n++) cyc(1);
				crc_enable_abort = 1;
				cyc(4);
				chk("crc_tx", crc_check_en, 0);
			end
		join
		cyc(10);
		chk("abort", aborts, 1);
		chk("model", m.bad, 0);
		crc_enable_abort = 0;
		cyc(20);
		end_sim();
	end
endmodule
`default_nettype wire
